// *** verilog/psc_pkg.sv ***
// package: command codes, mask layout, reset values and carrier types for the config-source block
package psc_pkg;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0]  CMD_OVERRIDE_MASK  = 8'hee;
   localparam logic [7:0]  CMD_TARGET_ADDRESS = 8'hef;

   // ************************************************************
   // override mask field positions
   // ************************************************************
   localparam int          MASK_W             = 16;
   localparam int          BIT_STACK          = 12;
   localparam int          BIT_SYNC           = 11;
   localparam int          BIT_FREE_HI        = 10;
   localparam int          BIT_COMP           = 9;
   localparam int          BIT_ADDRESS        = 8;
   localparam int          BIT_PHASE_OFFSET_SETTING     = 5;
   localparam int          BIT_FREE_LO        = 4;
   localparam int          BIT_TON_RISE       = 3;
   localparam int          BIT_OVERCURRENT    = 2;
   localparam int          BIT_SWITCH_RATE    = 1;
   localparam int          BIT_OUTPUT_VOLTAGE = 0;

   // ************************************************************
   // target address layout and reset values
   // ************************************************************
   localparam int          ADDR_W             = 7;
   localparam logic [15:0] MASK_RESET         = 16'h0000;
   localparam logic [6:0]  ADDR_RESET         = 7'h00;
   localparam logic [6:0]  RSVD_ADDR_0        = 7'h0c;
   localparam logic [6:0]  RSVD_ADDR_1        = 7'h28;
   localparam logic [6:0]  RSVD_ADDR_2        = 7'h37;
   localparam logic [6:0]  RSVD_ADDR_3        = 7'h61;

   // ************************************************************
   // setting widths
   // ************************************************************
   localparam int          STACK_W            = 4;
   localparam int          SYNC_W             = 4;
   localparam int          COMP_W             = 8;
   localparam int          ILV_W              = 8;
   localparam int          VAL_W              = 16;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic [STACK_W-1:0] stack;
      logic [SYNC_W-1:0]  sync;
      logic [COMP_W-1:0]  comp;
      logic [ILV_W-1:0]   phase_offset_setting;
      logic [VAL_W-1:0]   ton_rise;
      logic [VAL_W-1:0]   oc_fault_limit;
      logic [VAL_W-1:0]   oc_warn_limit;
      logic [VAL_W-1:0]   frequency_switch;
      logic [VAL_W-1:0]   output_voltage_source_bit_command;
      logic [VAL_W-1:0]   output_voltage_source_bit_scale_loop;
      logic [VAL_W-1:0]   output_voltage_source_bit_max;
      logic [VAL_W-1:0]   output_voltage_source_bit_min;
   } psc_cfg_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        word;
      logic [7:0]  code;
      logic [15:0] wdata;
   } psc_cmd_type;

   typedef struct packed {
      logic        ack;
      logic        nack;
      logic [15:0] rdata;
   } psc_rsp_type;

endpackage

// *** verilog/psc_source_select.sv ***
// per-setting choice between stored and strap-detected configuration values
`timescale 1ns/1ps

module psc_source_select (
   input  wire logic [15:0]          mask_i,     // override mask in force
   input  wire psc_pkg::psc_cfg_type nvm_cfg_i,  // stored values
   input  wire psc_pkg::psc_cfg_type pin_cfg_i,  // strap-detected values
   input  wire logic [6:0]           nvm_addr_i, // stored target address
   input  wire logic [6:0]           pin_addr_i, // strap-detected address
   output psc_pkg::psc_cfg_type      cfg_o,      // chosen values
   output logic [6:0]                addr_o      // chosen address
);

   // bits 15:13, 10, 7:6, 4 unused here; mask value 1 keeps the strap value
   always_comb begin
      cfg_o = nvm_cfg_i;
      if (mask_i[psc_pkg::BIT_STACK]) begin
         cfg_o.stack = pin_cfg_i.stack;
      end
      if (mask_i[psc_pkg::BIT_SYNC]) begin
         cfg_o.sync = pin_cfg_i.sync;
      end
      if (mask_i[psc_pkg::BIT_COMP]) begin
         cfg_o.comp = pin_cfg_i.comp;
      end
      if (mask_i[psc_pkg::BIT_PHASE_OFFSET_SETTING]) begin
         cfg_o.phase_offset_setting = pin_cfg_i.phase_offset_setting;
      end
      if (mask_i[psc_pkg::BIT_TON_RISE]) begin
         cfg_o.ton_rise = pin_cfg_i.ton_rise;
      end
      if (mask_i[psc_pkg::BIT_OVERCURRENT]) begin
         cfg_o.oc_fault_limit = pin_cfg_i.oc_fault_limit;
         cfg_o.oc_warn_limit  = pin_cfg_i.oc_warn_limit;
      end
      if (mask_i[psc_pkg::BIT_SWITCH_RATE]) begin
         cfg_o.frequency_switch = pin_cfg_i.frequency_switch;
      end
      if (mask_i[psc_pkg::BIT_OUTPUT_VOLTAGE]) begin
         cfg_o.output_voltage_source_bit_command    = pin_cfg_i.output_voltage_source_bit_command;
         cfg_o.output_voltage_source_bit_scale_loop = pin_cfg_i.output_voltage_source_bit_scale_loop;
         cfg_o.output_voltage_source_bit_max        = pin_cfg_i.output_voltage_source_bit_max;
         cfg_o.output_voltage_source_bit_min        = pin_cfg_i.output_voltage_source_bit_min;
      end
   end

   always_comb begin
      addr_o = mask_i[psc_pkg::BIT_ADDRESS] ? pin_addr_i : nvm_addr_i;
   end

endmodule

// *** verilog/psc_config_loader.sv ***
// config-source loader: override mask and target address commands, load at power-on and restore
//
// Notes on behaviour
// - override mask uses word write and word read
// - straps caught at power-on; mask writes stored, settings follow only at next load
// - stored values win unless mask bit is one
// - bit 12 picks stacking source
// - bit 11 picks synchronisation source
// - bit 9 picks compensation source
// - bit 8 picks bus address source
// - bit 5 picks phase offset source
// - bit 3 picks soft-start time source
// - bit 2 picks both overcurrent limits source
// - bit 1 picks switching frequency source
// - bit 0 picks output voltage group source
// - bits 10 and 4 are ignored
// - mask applied at power-on and restore-all
// - target address uses byte write and read
// - new address answers immediately
// - reserved addresses refused, address unchanged
`timescale 1ns/1ps

module psc_config_loader (
   input  wire logic                 sys_clk_i,     // system clock, 100 MHz
   input  wire logic                 rst_n_i,       // async reset, active low
   input  wire logic                 por_load_i,    // power-on load pulse
   input  wire logic                 restore_all_i, // restore-user-all pulse
   input  wire logic [15:0]          nvm_mask_i,    // stored override mask
   input  wire psc_pkg::psc_cfg_type nvm_cfg_i,     // stored setting values
   input  wire logic [6:0]           nvm_addr_i,    // stored target address
   input  wire psc_pkg::psc_cfg_type pin_cfg_i,     // strap-detected settings
   input  wire logic [6:0]           pin_addr_i,    // strap-detected address
   input  wire psc_pkg::psc_cmd_type cmd_i,         // command from bus layer
   input  wire logic [6:0]           bus_addr_i,    // address seen on the bus
   output psc_pkg::psc_rsp_type      rsp_o,         // command answer
   output logic                      addr_match_o,  // bus address is ours
   output psc_pkg::psc_cfg_type      cfg_o,         // settings in force
   output logic [6:0]                target_addr_o, // target address in force
   output logic [15:0]               mask_o,        // override mask in force
   output logic                      load_done_o    // load finished pulse
);

   // ************************************************************
   // state
   // ************************************************************
   logic [15:0]          mask_ff;
   logic [6:0]           addr_ff;
   psc_pkg::psc_cfg_type cfg_ff;
   psc_pkg::psc_cfg_type pin_cfg_ff;
   logic [6:0]           pin_addr_ff;
   logic                 load_done_ff;
   psc_pkg::psc_rsp_type rsp_ff;

   logic [15:0]          nxt_sel_mask;
   psc_pkg::psc_cfg_type nxt_sel_pin_cfg;
   logic [6:0]           nxt_sel_pin_addr;
   psc_pkg::psc_cfg_type nxt_cfg;
   logic [6:0]           nxt_addr;
   logic                 load_now;
   logic                 hit_mask;
   logic                 hit_addr;
   logic                 mask_wr_ok;
   logic                 addr_wr_ok;
   logic                 req_ok;

   function automatic logic is_reserved_addr(input logic [6:0] a);
      is_reserved_addr = (a == psc_pkg::RSVD_ADDR_0) || (a == psc_pkg::RSVD_ADDR_1) ||
                         (a == psc_pkg::RSVD_ADDR_2) || (a == psc_pkg::RSVD_ADDR_3);
   endfunction

   // ************************************************************
   // load source selection
   // ************************************************************
   assign load_now = por_load_i | restore_all_i;

   // power-on uses the stored mask and live straps; restore uses kept ones
   always_comb begin
      if (por_load_i) begin
         nxt_sel_mask     = nvm_mask_i;
         nxt_sel_pin_cfg  = pin_cfg_i;
         nxt_sel_pin_addr = pin_addr_i;
      end else begin
         nxt_sel_mask     = mask_ff;
         nxt_sel_pin_cfg  = pin_cfg_ff;
         nxt_sel_pin_addr = pin_addr_ff;
      end
   end

   psc_source_select u_select (
      .mask_i     (nxt_sel_mask),
      .nvm_cfg_i  (nvm_cfg_i),
      .pin_cfg_i  (nxt_sel_pin_cfg),
      .nvm_addr_i (nvm_addr_i),
      .pin_addr_i (nxt_sel_pin_addr),
      .cfg_o      (nxt_cfg),
      .addr_o     (nxt_addr)
   );

   // ************************************************************
   // strap capture
   // ************************************************************
   // straps are kept only from the power-on load, never re-detected
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_cfg_ff  <= '0;
         pin_addr_ff <= psc_pkg::ADDR_RESET;
      end else if (por_load_i) begin
         pin_cfg_ff  <= pin_cfg_i;
         pin_addr_ff <= pin_addr_i;
      end
   end

   // ************************************************************
   // command decode
   // ************************************************************
   assign hit_mask   = cmd_i.valid && (cmd_i.code == psc_pkg::CMD_OVERRIDE_MASK);
   assign hit_addr   = cmd_i.valid && (cmd_i.code == psc_pkg::CMD_TARGET_ADDRESS);
   assign mask_wr_ok = hit_mask && cmd_i.write && cmd_i.word && !load_now;
   assign addr_wr_ok = hit_addr && cmd_i.write && !cmd_i.word && !load_now &&
                       !is_reserved_addr(cmd_i.wdata[6:0]);
   // word access only on the mask, byte access only on the address
   assign req_ok     = (hit_mask && cmd_i.word && (!cmd_i.write || mask_wr_ok)) ||
                       (hit_addr && !cmd_i.word && (!cmd_i.write || addr_wr_ok));

   // ************************************************************
   // override mask
   // ************************************************************
   // all sixteen bits stored as written; unused ones steer nothing
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_ff <= psc_pkg::MASK_RESET;
      end else if (por_load_i) begin
         mask_ff <= nvm_mask_i;
      end else if (mask_wr_ok) begin
         mask_ff <= cmd_i.wdata;
      end
   end

   // ************************************************************
   // target address
   // ************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_ff <= psc_pkg::ADDR_RESET;
      end else if (load_now) begin
         addr_ff <= nxt_addr;
      end else if (addr_wr_ok) begin
         addr_ff <= cmd_i.wdata[6:0];
      end
   end

   // compare against the live register so a new address counts next cycle
   assign addr_match_o = (bus_addr_i == addr_ff);

   // ************************************************************
   // settings in force
   // ************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_ff <= '0;
      end else if (load_now) begin
         cfg_ff <= nxt_cfg;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_done_ff <= 1'b0;
      end else begin
         load_done_ff <= load_now;
      end
   end

   // ************************************************************
   // command answer
   // ************************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.ack  <= req_ok;
         rsp_ff.nack <= cmd_i.valid && !req_ok;
         if (hit_mask && !cmd_i.write && cmd_i.word) begin
            rsp_ff.rdata <= mask_ff;
         end else if (hit_addr && !cmd_i.write && !cmd_i.word) begin
            rsp_ff.rdata <= {9'h000, addr_ff};
         end else begin
            rsp_ff.rdata <= 16'h0000;
         end
      end
   end

   assign rsp_o         = rsp_ff;
   assign cfg_o         = cfg_ff;
   assign target_addr_o = addr_ff;
   assign mask_o        = mask_ff;
   assign load_done_o   = load_done_ff;

endmodule

// *** sim/psc_host_model.sv ***
// bus host model issuing byte and word commands to the loader
`timescale 1ns/1ps

module psc_host_model (
   input  wire logic                 sys_clk_i, // clock
   input  wire logic                 send_i,    // issue request
   input  wire psc_pkg::psc_cmd_type req_i,     // request
   output psc_pkg::psc_cmd_type      cmd_o      // command to block
);
   psc_pkg::psc_cmd_type nxt_cmd;

   // idle bus shows the inverse of the last data so stale values are not mistaken
   always_comb begin
      nxt_cmd       = req_i;
      nxt_cmd.valid = send_i;
      if (!send_i) begin
         nxt_cmd.wdata = ~req_i.wdata;
      end else if (req_i.code == psc_pkg::CMD_OVERRIDE_MASK) begin
         nxt_cmd.wdata = req_i.wdata & 16'h1f3f;
      end
   end

   always @(posedge sys_clk_i) begin
      cmd_o <= nxt_cmd;
   end
endmodule

// *** sim/psc_loader_checker.sv ***
// concurrent checks on the config-source loader ports
`timescale 1ns/1ps

module psc_loader_checker (
   input  wire logic                 sys_clk_i,     // clock
   input  wire logic                 rst_n_i,       // reset
   input  wire logic                 por_load_i,    // por load
   input  wire logic                 restore_all_i, // restore
   input  wire logic [15:0]          nvm_mask_i,    // nvm mask
   input  wire psc_pkg::psc_cfg_type nvm_cfg_i,     // nvm cfg
   input  wire logic [6:0]           nvm_addr_i,    // nvm addr
   input  wire psc_pkg::psc_cfg_type pin_cfg_i,     // strap cfg
   input  wire logic [6:0]           pin_addr_i,    // strap addr
   input  wire psc_pkg::psc_cmd_type cmd_i,         // command
   input  wire logic [6:0]           bus_addr_i,    // bus addr
   input  wire psc_pkg::psc_rsp_type rsp_o,         // answer
   input  wire logic                 addr_match_o,  // match
   input  wire psc_pkg::psc_cfg_type cfg_o,         // cfg
   input  wire logic [6:0]           target_addr_o, // addr
   input  wire logic [15:0]          mask_o,        // mask
   input  wire logic                 load_done_o    // done
);
   psc_pkg::psc_cfg_type pin_ff, por_exp, rst_exp;
   logic [6:0]           pin_addr_ff, por_addr, rst_addr;
   logic                 idle, rsvd, wr, rd;

   function automatic psc_pkg::psc_cfg_type pick(logic [15:0] m, psc_pkg::psc_cfg_type n, p);
      logic [151:0] s;
      s = {{4{m[12]}}, {4{m[11]}}, {8{m[9]}}, {8{m[5]}}, {16{m[3]}}, {32{m[2]}}, {16{m[1]}}, {64{m[0]}}};
      return (p & s) | (n & ~s);
   endfunction

   assign idle     = !por_load_i && !restore_all_i;
   assign rsvd     = cmd_i.wdata[6:0] inside {7'h0c, 7'h28, 7'h37, 7'h61};
   assign wr       = cmd_i.valid && cmd_i.write && idle;
   assign rd       = cmd_i.valid && !cmd_i.write && idle;
   assign por_exp  = pick(nvm_mask_i, nvm_cfg_i, pin_cfg_i);
   assign rst_exp  = pick(mask_o, nvm_cfg_i, pin_ff);
   assign por_addr = nvm_mask_i[8] ? pin_addr_i : nvm_addr_i;
   assign rst_addr = mask_o[8] ? pin_addr_ff : nvm_addr_i;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_ff      <= '0;
         pin_addr_ff <= '0;
      end else if (por_load_i) begin
         pin_ff      <= pin_cfg_i;
         pin_addr_ff <= pin_addr_i;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   mask_write_a:
      assert property (wr && cmd_i.word && cmd_i.code == 8'hee |=> rsp_o.ack && mask_o == $past(cmd_i.wdata))
      else $error("mask write not stored");
   mask_read_a:
      assert property (rd && cmd_i.word && cmd_i.code == 8'hee |=> rsp_o.ack && rsp_o.rdata == $past(mask_o))
      else $error("mask read wrong");
   mask_byte_a:
      assert property (cmd_i.valid && !cmd_i.word && cmd_i.code == 8'hee |=> rsp_o.nack)
      else $error("byte access to mask accepted");
   addr_write_a:
      assert property (wr && !cmd_i.word && cmd_i.code == 8'hef && !rsvd |=> rsp_o.ack
         && target_addr_o == $past(cmd_i.wdata[6:0]) && addr_match_o == (bus_addr_i == target_addr_o))
      else $error("address write wrong");
   addr_read_a:
      assert property (rd && !cmd_i.word && cmd_i.code == 8'hef |=> rsp_o.ack
         && rsp_o.rdata == {9'h000, $past(target_addr_o)})
      else $error("address read wrong");
   addr_rsvd_a:
      assert property (wr && cmd_i.code == 8'hef && rsvd |=> rsp_o.nack
         && $stable(target_addr_o))
      else $error("reserved address accepted");
   por_load_a:
      assert property (por_load_i |=> load_done_o && mask_o == $past(nvm_mask_i) && cfg_o == $past(por_exp)
         && target_addr_o == $past(por_addr))
      else $error("power-on load wrong");
   restore_a:
      assert property (restore_all_i && !por_load_i |=> load_done_o && $stable(mask_o)
         && cfg_o == $past(rst_exp) && target_addr_o == $past(rst_addr))
      else $error("restore load wrong");
endmodule

bind psc_config_loader psc_loader_checker chk (.*);

// *** sim/tb.sv ***
// self-checking bench for the config-source loader
`timescale 1ns/1ps

module tb;
   localparam psc_pkg::psc_cfg_type NVM_V = {19{8'h3c}};
   localparam psc_pkg::psc_cfg_type PIN_V = {19{8'hc3}};
   logic                 sys_clk_i, rst_n_i, por_load_i, restore_all_i, send, addr_match_o, load_done_o;
   logic [15:0]          nvm_mask_i, mask_o;
   logic [6:0]           nvm_addr_i, pin_addr_i, bus_addr_i, target_addr_o;
   psc_pkg::psc_cfg_type nvm_cfg_i, pin_cfg_i, cfg_o;
   psc_pkg::psc_cmd_type req, cmd_i;
   psc_pkg::psc_rsp_type rsp_o;
   int                   failures, checks;
   int                   bl[9] = '{12, 11, 9, 8, 5, 3, 2, 1, 0};
   logic [6:0]           rsvd[4] = '{7'h0c, 7'h28, 7'h37, 7'h61};

   psc_host_model host (.sys_clk_i(sys_clk_i), .send_i(send), .req_i(req), .cmd_o(cmd_i));
   psc_config_loader dut (
      .sys_clk_i     (sys_clk_i),
      .rst_n_i       (rst_n_i),
      .por_load_i    (por_load_i),
      .restore_all_i (restore_all_i),
      .nvm_mask_i    (nvm_mask_i),
      .nvm_cfg_i     (nvm_cfg_i),
      .nvm_addr_i    (nvm_addr_i),
      .pin_cfg_i     (pin_cfg_i),
      .pin_addr_i    (pin_addr_i),
      .cmd_i         (cmd_i),
      .bus_addr_i    (bus_addr_i),
      .rsp_o         (rsp_o),
      .addr_match_o  (addr_match_o),
      .cfg_o         (cfg_o),
      .target_addr_o (target_addr_o),
      .mask_o        (mask_o),
      .load_done_o   (load_done_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   function automatic psc_pkg::psc_cfg_type want(logic [15:0] m, psc_pkg::psc_cfg_type n, p);
      logic [151:0] s;
      s = {{4{m[12]}}, {4{m[11]}}, {8{m[9]}}, {8{m[5]}}, {16{m[3]}}, {32{m[2]}}, {16{m[1]}}, {64{m[0]}}};
      return (p & s) | (n & ~s);
   endfunction

   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_cfg(input string what, input psc_pkg::psc_cfg_type exp, input psc_pkg::psc_cfg_type got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ************************************************************
   // bus and load drivers
   // ************************************************************
   task automatic bus(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] data);
      req  = '{valid: 1'b1, write: wr, word: wd, code: code, wdata: data};
      send = 1'b1;
      @(posedge sys_clk_i);
      #1;
      send = 1'b0;
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic load(input logic por);
      int n;
      por_load_i    = por;
      restore_all_i = !por;
      @(posedge sys_clk_i);
      #1;
      por_load_i    = 1'b0;
      restore_all_i = 1'b0;
      for (n = 0; n < 4 && load_done_o !== 1'b1; n++) begin
         @(posedge sys_clk_i);
         #1;
      end
      if (n == 4) begin
         failures++;
         wrap_up;
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_por;
      load(1'b1);
      chk_cfg("por stored", NVM_V, cfg_o);
      chk16("por addr stored", 16'h0022, {9'h000, target_addr_o});
      nvm_mask_i = 16'h1f3f;
      load(1'b1);
      chk_cfg("por strap", PIN_V, cfg_o);
      chk16("por addr strap", 16'h0044, {9'h000, target_addr_o});
      $display("test por done");
   endtask

   task automatic t_mask;
      bus(1'b1, 1'b1, 8'hee, 16'h0412);
      chk16("mask ack", 16'h0001, {15'h0000, rsp_o.ack});
      chk16("mask now", 16'h0412, mask_o);
      bus(1'b0, 1'b1, 8'hee, 16'h0000);
      chk16("mask read", 16'h0412, rsp_o.rdata);
      bus(1'b0, 1'b0, 8'hee, 16'h0000);
      chk16("mask byte nack", 16'h0001, {15'h0000, rsp_o.nack});
      $display("test mask done");
   endtask

   task automatic t_bits;
      pin_cfg_i  = {19{8'h99}};
      pin_addr_i = 7'h11;
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, 1'b1, 8'hee, 16'h0001 << bl[i]);
         load(1'b0);
         chk_cfg("restore cfg", want(16'h0001 << bl[i], NVM_V, PIN_V), cfg_o);
         chk16("restore addr", (bl[i] == 8) ? 16'h0044 : 16'h0022, {9'h000, target_addr_o});
         chk16("mask kept", 16'h0001 << bl[i], mask_o);
      end
      $display("test bits done");
   endtask

   task automatic t_addr;
      bus_addr_i = 7'h5a;
      bus(1'b1, 1'b0, 8'hef, 16'hffda);
      chk16("addr ack", 16'h0001, {15'h0000, rsp_o.ack});
      chk16("addr new", 16'h005a, {9'h000, target_addr_o});
      chk16("addr match", 16'h0001, {15'h0000, addr_match_o});
      bus(1'b0, 1'b0, 8'hef, 16'h0000);
      chk16("addr read", 16'h005a, rsp_o.rdata);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 1'b0, 8'hef, {9'h000, rsvd[i]});
         chk16("rsvd nack", 16'h0001, {15'h0000, rsp_o.nack});
         chk16("rsvd kept", 16'h005a, {9'h000, target_addr_o});
      end
      bus(1'b1, 1'b1, 8'hef, 16'h0033);
      chk16("addr word nack", 16'h0001, {15'h0000, rsp_o.nack});
      $display("test addr done");
   endtask

   // unknown code, then a mask write landing in the same cycle as a restore
   task automatic t_clash;
      bus(1'b0, 1'b1, 8'hed, 16'h0000);
      chk16("unknown nack", 16'h0001, {15'h0000, rsp_o.nack});
      req           = '{valid: 1'b1, write: 1'b1, word: 1'b1, code: 8'hee, wdata: 16'h0102};
      send          = 1'b1;
      @(posedge sys_clk_i);
      #1;
      send          = 1'b0;
      restore_all_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      restore_all_i = 1'b0;
      chk16("clash nack", 16'h0001, {15'h0000, rsp_o.nack});
      chk16("clash mask kept", 16'h0001, mask_o);
      chk_cfg("clash cfg", want(16'h0001, NVM_V, PIN_V), cfg_o);
      chk16("clash addr", 16'h0022, {9'h000, target_addr_o});
      $display("test clash done");
   endtask

   initial begin
      failures      = 0;
      checks        = 0;
      rst_n_i       = 1'b0;
      por_load_i    = 1'b0;
      restore_all_i = 1'b0;
      send          = 1'b0;
      req           = '0;
      nvm_mask_i    = 16'h0410;
      nvm_cfg_i     = NVM_V;
      nvm_addr_i    = 7'h22;
      pin_cfg_i     = PIN_V;
      pin_addr_i    = 7'h44;
      bus_addr_i    = 7'h00;
      repeat (4) @(posedge sys_clk_i);
      #1;
      rst_n_i = 1'b1;
      chk16("reset mask", 16'h0000, mask_o);
      chk16("reset addr", 16'h0000, {9'h000, target_addr_o});
      t_por;
      t_mask;
      t_bits;
      t_addr;
      t_clash;
      wrap_up;
   end
endmodule
